// ---- inc/rfh_pkg.sv ----
// constants for the receive frame header status block
package rfh_pkg;
    // register indices; byte address is four times the index
    localparam logic [6:0] RFH_IDX_STATUS = 7'h7C;
    localparam logic [6:0] RFH_IDX_COUNT = 7'h7E;
    localparam logic [6:0] RFH_IDX_CTRL = 7'h60;
    localparam logic [6:0] RFH_IDX_INFO = 7'h61;
    localparam int RFH_ADR_W = 9;
    // status word field positions
    localparam int RFH_BIT_VALID = 15;
    localparam int RFH_BIT_ICMP = 13;
    localparam int RFH_BIT_IP = 12;
    localparam int RFH_BIT_TCP = 11;
    localparam int RFH_BIT_UDP = 10;
    localparam int RFH_BIT_BCAST = 7;
    localparam int RFH_BIT_MCAST = 6;
    localparam int RFH_BIT_UCAST = 5;
    localparam int RFH_BIT_SYMBOL = 4;
    localparam int RFH_BIT_ETYPE = 3;
    localparam int RFH_BIT_LONG = 2;
    localparam int RFH_BIT_RUNT = 1;
    localparam int RFH_BIT_CRC = 0;
    // control and info register fields
    localparam int RFH_BIT_PASS_BAD = 0;
    localparam int RFH_BIT_OVERFLOW = 8;
    localparam logic RFH_PASS_BAD_RST = 1'b0;
    // widths and limits
    localparam int RFH_STATUS_W = 16;
    localparam int RFH_COUNT_W = 12;
    localparam int RFH_ENTRY_W = RFH_STATUS_W + RFH_COUNT_W;
    localparam logic [15:0] RFH_ETYPE_MIN = 16'h05DC;
    localparam logic [11:0] RFH_MAX_LEN = 12'h7D0;
    localparam logic [47:0] RFH_BCAST_ADDR = 48'hFFFF_FFFF_FFFF;
    localparam int RFH_GROUP_BIT = 40;
    localparam int RFH_DEPTH_DEF = 4;
endpackage

// ---- hdl/rfh_rx_status.sv ----
// receive frame header status and byte count with wishbone registers
// How it works
// (R1) valid flag bit 15 set when the head frame and its status are complete
// (R2) valid flag clear while nothing pending or head frame still arriving
// (R3) bit 13 flags a bad ICMP checksum
// (R4) bit 12 flags a bad IP header checksum
// (R5) bit 11 flags a bad TCP checksum
// (R6) bit 10 flags a bad UDP checksum
// (R7) bit 7 flags a broadcast destination
// (R8) bit 6 flags a multicast destination, broadcast included
// (R9) bit 5 flags a unicast destination
// (R10) bit 4 flags a media interface symbol error during the frame
// (R11) bit 3 set when length/type exceeds 1500, clear for length-coded frames
// (R12) frame type bit carries no meaning for runt frames
// (R13) bit 2 flags frames longer than 2000 bytes
// (R14) over-length frames kept only when pass-bad is on, else dropped
// (R15) over-length frames are never cut; full byte count is reported
// (R16) bit 1 flags collision-damaged or early-terminated runt frames
// (R17) runt frames kept only when pass-bad is on, else dropped
// (R18) bit 0 flags a frame check sequence mismatch
// (R19) CRC error frames kept only when pass-bad is on, else dropped
// (R20) byte count in bits 11-0, bits 15-12 read zero
// (R21) one frame shown at a time; host reads at most pending-count times
// (R22) status and byte count always describe the same frame
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps
module rfh_rx_status
    import rfh_pkg::*;
#(
    parameter int DEPTH = RFH_DEPTH_DEF
)(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [RFH_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rx_done,
    input wire logic [11:0] rx_len,
    input wire logic [47:0] rx_dest_addr,
    input wire logic [15:0] rx_len_type,
    input wire logic rx_icmp_cksum_err,
    input wire logic rx_ip_cksum_err,
    input wire logic rx_tcp_cksum_err,
    input wire logic rx_udp_cksum_err,
    input wire logic rx_symbol_err,
    input wire logic rx_runt,
    input wire logic rx_crc_err,
    output logic frame_kept,
    output logic frame_dropped
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    // the queue must wrap on its pointers, so only powers of two serve
    generate
        if (DEPTH < 2 || DEPTH > 128 || (DEPTH & (DEPTH - 1)) != 0)
        begin : g_bad_depth
            $error("DEPTH must be a power of two from 2 to 128");
        end
    endgenerate

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic [DEPTH-1:0][RFH_ENTRY_W-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [CW-1:0] cnt;
        logic pass_bad;
        logic overflow;
        logic kept;
        logic dropped;
    } rfh_state_t;

    rfh_state_t state_reg;
    rfh_state_t state_next;

    logic req;
    logic stat_req;
    logic pop;
    logic push;
    logic keep;
    logic [6:0] idx;
    logic [RFH_STATUS_W-1:0] st;
    logic [RFH_ENTRY_W-1:0] head;
    logic [RFH_COUNT_W-1:0] head_len;

    // next state: bus slave, frame queue and drop decision
    always_comb
    begin
        state_next = state_reg;
        state_next.ack = 1'b0;
        state_next.kept = 1'b0;
        state_next.dropped = 1'b0;
        idx = wb_adr_i[8:2];
        // one answer per request; ack drops the cycle after it is given
        req = wb_cyc_i && wb_stb_i && !state_reg.ack;
        stat_req = req && !wb_we_i && idx == RFH_IDX_STATUS;
        head = state_reg.mem[state_reg.rd];
        head_len = head[RFH_ENTRY_W-1:RFH_STATUS_W];
        // reading the byte count retires the head frame, so a reader
        // fetches status first and count last for each frame
        pop = req && !wb_we_i && idx == RFH_IDX_COUNT && state_reg.cnt != '0; // R21

        // status word assembled from the finished frame
        st = '0;
        st[RFH_BIT_ICMP] = rx_icmp_cksum_err; // R3
        st[RFH_BIT_IP] = rx_ip_cksum_err; // R4
        st[RFH_BIT_TCP] = rx_tcp_cksum_err; // R5
        st[RFH_BIT_UDP] = rx_udp_cksum_err; // R6
        st[RFH_BIT_BCAST] = rx_dest_addr == RFH_BCAST_ADDR; // R7
        st[RFH_BIT_MCAST] = rx_dest_addr[RFH_GROUP_BIT]; // R8
        st[RFH_BIT_UCAST] = !rx_dest_addr[RFH_GROUP_BIT]; // R9
        st[RFH_BIT_SYMBOL] = rx_symbol_err; // R10
        // not masked for runts: the bit is simply meaningless there
        st[RFH_BIT_ETYPE] = rx_len_type > RFH_ETYPE_MIN; // R11 R12
        st[RFH_BIT_LONG] = rx_len > RFH_MAX_LEN; // R13
        st[RFH_BIT_RUNT] = rx_runt; // R16
        st[RFH_BIT_CRC] = rx_crc_err; // R18

        // bad frames survive only with pass-bad set
        keep = !(st[RFH_BIT_LONG] || rx_runt || rx_crc_err) || state_reg.pass_bad; // R14 R17 R19
        // a full queue loses the new frame rather than corrupt the head
        push = rx_done && keep && (state_reg.cnt != CW'(DEPTH) || pop);

        if (push)
        begin
            // status and count enter as one entry, full length kept
            state_next.mem[state_reg.wr] = {rx_len, st}; // R15 R22
            state_next.wr = state_reg.wr + AW'(1);
        end
        if (pop)
        begin
            state_next.rd = state_reg.rd + AW'(1);
        end
        state_next.cnt = state_reg.cnt + CW'(push) - CW'(pop);
        state_next.kept = push;
        state_next.dropped = rx_done && !push;

        // register writes take effect on the acking edge
        if (req && wb_we_i && wb_sel_i[0])
        begin
            if (idx == RFH_IDX_CTRL)
            begin
                state_next.pass_bad = wb_dat_i[RFH_BIT_PASS_BAD];
            end
            if (idx == RFH_IDX_INFO && wb_sel_i[1] && wb_dat_i[RFH_BIT_OVERFLOW])
            begin
                state_next.overflow = 1'b0;
            end
        end
        // a new loss wins over a clear in the same cycle
        if (rx_done && keep && !push)
        begin
            state_next.overflow = 1'b1;
        end

        // read data; unmapped indices answer with zero
        state_next.dat = '0;
        if (req)
        begin
            state_next.ack = 1'b1;
            if (!wb_we_i)
            begin
                unique case (idx)
                    RFH_IDX_STATUS:
                    begin
                        if (state_reg.cnt != '0)
                        begin
                            // only whole frames reach the queue
                            state_next.dat[RFH_STATUS_W-1:0] = head[RFH_STATUS_W-1:0];
                            state_next.dat[RFH_BIT_VALID] = 1'b1; // R1 R2
                        end
                    end
                    RFH_IDX_COUNT:
                    begin
                        if (state_reg.cnt != '0)
                        begin
                            state_next.dat[RFH_COUNT_W-1:0] = head[RFH_ENTRY_W-1:RFH_STATUS_W]; // R20 R22
                        end
                    end
                    RFH_IDX_CTRL:
                    begin
                        state_next.dat[RFH_BIT_PASS_BAD] = state_reg.pass_bad;
                    end
                    RFH_IDX_INFO:
                    begin
                        state_next.dat[CW-1:0] = state_reg.cnt;
                        state_next.dat[RFH_BIT_OVERFLOW] = state_reg.overflow;
                    end
                    default:
                    begin
                        state_next.dat = '0;
                    end
                endcase
            end
        end
    end

    // single state register
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= '0;
            state_reg.pass_bad <= RFH_PASS_BAD_RST;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // outputs straight from the state register
    assign wb_ack_o = state_reg.ack;
    assign wb_dat_o = state_reg.dat;
    assign frame_kept = state_reg.kept;
    assign frame_dropped = state_reg.dropped;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // valid in the answer mirrors whether a frame was pending at request
    a_valid_flag_pending: assert property ( // R1
        stat_req && state_reg.cnt != '0 |=> wb_ack_o && wb_dat_o[RFH_BIT_VALID])
        else $error("valid flag missing with a frame pending");
    a_valid_flag_empty: assert property ( // R2
        stat_req && state_reg.cnt == '0 |=> wb_ack_o && wb_dat_o[15:0] == 16'h0000)
        else $error("valid flag set with no frame pending");
    a_icmp_flag_stored: assert property ( // R3
        push |=> state_reg.mem[$past(state_reg.wr)][RFH_BIT_ICMP] == $past(rx_icmp_cksum_err))
        else $error("icmp checksum flag not stored");
    a_ip_flag_stored: assert property ( // R4
        push |=> state_reg.mem[$past(state_reg.wr)][RFH_BIT_IP] == $past(rx_ip_cksum_err))
        else $error("ip checksum flag not stored");
    a_tcp_flag_stored: assert property ( // R5
        push |=> state_reg.mem[$past(state_reg.wr)][RFH_BIT_TCP] == $past(rx_tcp_cksum_err))
        else $error("tcp checksum flag not stored");
    a_udp_flag_stored: assert property ( // R6
        push |=> state_reg.mem[$past(state_reg.wr)][RFH_BIT_UDP] == $past(rx_udp_cksum_err))
        else $error("udp checksum flag not stored");
    a_bcast_flag_set: assert property ( // R7
        push && rx_dest_addr == RFH_BCAST_ADDR
        |=> state_reg.mem[$past(state_reg.wr)][RFH_BIT_BCAST:RFH_BIT_UCAST] == 3'h6)
        else $error("broadcast frame not classed");
    a_mcast_flag_set: assert property ( // R8
        push && rx_dest_addr[RFH_GROUP_BIT]
        |=> state_reg.mem[$past(state_reg.wr)][RFH_BIT_MCAST])
        else $error("multicast flag missing");
    a_ucast_flag_set: assert property ( // R9
        push && !rx_dest_addr[RFH_GROUP_BIT]
        |=> state_reg.mem[$past(state_reg.wr)][RFH_BIT_BCAST:RFH_BIT_UCAST] == 3'h1)
        else $error("unicast frame not classed");
    a_symbol_flag_stored: assert property ( // R10
        push |=> state_reg.mem[$past(state_reg.wr)][RFH_BIT_SYMBOL] == $past(rx_symbol_err))
        else $error("symbol error flag not stored");
    a_etype_flag_stored: assert property ( // R11
        push |=> state_reg.mem[$past(state_reg.wr)][RFH_BIT_ETYPE]
            == ($past(rx_len_type) > 16'h05DC))
        else $error("frame type flag wrong");
    a_long_flag_stored: assert property ( // R13
        push |=> state_reg.mem[$past(state_reg.wr)][RFH_BIT_LONG] == ($past(rx_len) > 12'h7D0))
        else $error("too-long flag wrong");
    a_bad_frame_drop: assert property ( // R14
        rx_done && !state_reg.pass_bad && (rx_len > 12'h7D0 || rx_runt || rx_crc_err)
        |=> frame_dropped && !frame_kept && $stable(state_reg.wr))
        else $error("bad frame kept without pass-bad");
    a_full_length_kept: assert property ( // R15
        push |=> state_reg.mem[$past(state_reg.wr)][27:16] == $past(rx_len))
        else $error("byte count altered on entry");
    a_runt_flag_stored: assert property ( // R16
        push |=> state_reg.mem[$past(state_reg.wr)][RFH_BIT_RUNT] == $past(rx_runt))
        else $error("runt flag not stored");
    a_runt_pass_bad: assert property ( // R17
        rx_done && rx_runt && state_reg.pass_bad && state_reg.cnt == '0 |=> frame_kept)
        else $error("runt frame dropped with pass-bad set");
    a_crc_flag_stored: assert property ( // R18
        push |=> state_reg.mem[$past(state_reg.wr)][RFH_BIT_CRC] == $past(rx_crc_err))
        else $error("crc flag not stored");
    a_crc_drop_count: assert property ( // R19
        rx_done && rx_crc_err && !state_reg.pass_bad
        |=> state_reg.cnt == $past(state_reg.cnt) - CW'($past(pop)))
        else $error("crc frame entered the queue");
    a_count_upper_zero: assert property ( // R20
        wb_ack_o && $past(req && !wb_we_i && idx == RFH_IDX_COUNT) |-> wb_dat_o[31:12] == 20'h0)
        else $error("byte count upper bits not zero");
    a_one_frame_retired: assert property ( // R21
        pop && !push |=> state_reg.cnt == $past(state_reg.cnt) - CW'(1)
            && state_reg.rd == $past(state_reg.rd) + AW'(1))
        else $error("count read did not retire exactly one frame");
    a_status_count_pair: assert property ( // R22
        stat_req && state_reg.cnt != '0 ##3 pop
        |=> wb_dat_o[RFH_COUNT_W-1:0] == $past(head_len, 4))
        else $error("count answer from another frame than its status");
    a_ack_one_cycle: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    // bus answers: always one cycle late, quiet otherwise
    a_ack_after_req: assert property (
        req |=> wb_ack_o)
        else $error("request not answered in the next cycle");
    a_dat_idle_zero: assert property (
        !wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    a_reserved_zero: assert property ( // R1
        wb_ack_o && $past(stat_req) |-> wb_dat_o[31:16] == 16'h0 && !wb_dat_o[14]
            && wb_dat_o[9:8] == 2'b00)
        else $error("reserved status bits not zero");
    a_ctrl_readback: assert property ( // R14
        req && !wb_we_i && idx == RFH_IDX_CTRL
        |=> wb_dat_o[RFH_BIT_PASS_BAD] == $past(state_reg.pass_bad))
        else $error("pass-bad setting read back wrong");
    a_pass_bad_written: assert property ( // R14
        req && wb_we_i && wb_sel_i[0] && idx == RFH_IDX_CTRL
        |=> state_reg.pass_bad == $past(wb_dat_i[RFH_BIT_PASS_BAD]))
        else $error("pass-bad write lost");

    // every finished frame gets exactly one verdict, and only then
    a_done_answered: assert property (
        rx_done |=> frame_kept != frame_dropped)
        else $error("frame neither kept nor dropped, or both");
    a_no_spurious_pulse: assert property (
        !rx_done |=> !frame_kept && !frame_dropped)
        else $error("frame verdict without a finished frame");
    a_good_frame_kept: assert property ( // R1
        rx_done && !rx_runt && !rx_crc_err && rx_len <= RFH_MAX_LEN
        && state_reg.cnt != CW'(DEPTH) |=> frame_kept)
        else $error("good frame dropped with room in the queue");
    a_runt_dropped: assert property ( // R17
        rx_done && rx_runt && !state_reg.pass_bad |=> frame_dropped)
        else $error("runt frame kept without pass-bad");
    a_crc_pass_kept: assert property ( // R19
        rx_done && rx_crc_err && state_reg.pass_bad && state_reg.cnt == '0 |=> frame_kept)
        else $error("crc frame dropped with pass-bad set");
    a_long_pass_kept: assert property ( // R14
        rx_done && rx_len > RFH_MAX_LEN && state_reg.pass_bad && state_reg.cnt == '0
        |=> frame_kept)
        else $error("too-long frame dropped with pass-bad set");
    a_dropped_queue_still: assert property ( // R14 R17 R19
        frame_dropped |-> $stable(state_reg.wr))
        else $error("dropped frame moved the write pointer");
    a_dest_class_excl: assert property ( // R8 R9
        push |=> state_reg.mem[$past(state_reg.wr)][RFH_BIT_UCAST]
            != state_reg.mem[$past(state_reg.wr)][RFH_BIT_MCAST])
        else $error("frame marked both unicast and multicast");

    // queue bookkeeping; a lost frame must leave a sticky trace
    a_count_in_range: assert property ( // R21
        state_reg.cnt <= CW'(DEPTH))
        else $error("pending count beyond queue depth");
    a_push_counts_up: assert property ( // R21
        push && !pop |=> state_reg.cnt == $past(state_reg.cnt) + CW'(1))
        else $error("kept frame not counted");
    a_empty_no_pop: assert property ( // R2 R21
        req && !wb_we_i && idx == RFH_IDX_COUNT && state_reg.cnt == '0
        |=> wb_dat_o == 32'h0 && $stable(state_reg.rd))
        else $error("count read on an empty queue retired a frame");
    a_full_drop_flag: assert property (
        rx_done && !rx_runt && !rx_crc_err && rx_len <= RFH_MAX_LEN
        && state_reg.cnt == CW'(DEPTH) && !pop |=> frame_dropped && state_reg.overflow)
        else $error("frame taken into a full queue");
    a_overflow_sticky: assert property (
        state_reg.overflow && !(req && wb_we_i && idx == RFH_IDX_INFO)
        |=> state_reg.overflow)
        else $error("overflow flag cleared without a write");
    a_info_readback: assert property ( // R21
        req && !wb_we_i && idx == RFH_IDX_INFO
        |=> wb_dat_o[CW-1:0] == $past(state_reg.cnt))
        else $error("pending count read back wrong");

    c_frame_kept: cover property (rx_done ##1 frame_kept);
    c_bad_dropped: cover property (rx_done && rx_crc_err ##1 frame_dropped);
    c_status_then_count: cover property (stat_req ##[2:8] pop);
    c_queue_full: cover property (state_reg.cnt == CW'(DEPTH));
    c_overflow_drop: cover property (rx_done && state_reg.cnt == CW'(DEPTH) ##1 frame_dropped);
endmodule

// ---- verif/rfh_mac_model.sv ----
// stand-in for the receive mac that hands finished frames to the status block
`timescale 1ns/1ps
module rfh_mac_model (
    input wire logic clk,
    output logic rx_done,
    output logic [11:0] rx_len,
    output logic [47:0] rx_dest_addr,
    output logic [15:0] rx_len_type,
    output logic [6:0] rx_err
);
    // err order: icmp ip tcp udp symbol runt crc
    initial
    begin
        rx_done = 1'b0;
        rx_len = 12'h000;
        rx_dest_addr = 48'h0;
        rx_len_type = 16'h0000;
        rx_err = 7'h00;
    end

    // fields hold only for the done cycle; inverted after so stale reads cannot match
    task automatic send(input logic [11:0] len, input logic [47:0] da,
        input logic [15:0] lt, input logic [6:0] e);
        @(posedge clk);
        rx_done <= 1'b1;
        rx_len <= len;
        rx_dest_addr <= da;
        rx_len_type <= lt;
        rx_err <= e;
        @(posedge clk);
        rx_done <= 1'b0;
        rx_len <= ~len;
        rx_dest_addr <= ~da;
        rx_len_type <= ~lt;
        rx_err <= ~e;
    endtask
endmodule

// ---- verif/tb.sv ----
// self-checking bench for the receive frame header status block
`timescale 1ns/1ps
module tb;
    import rfh_pkg::*;
    localparam logic [8:0] st_adr = {RFH_IDX_STATUS, 2'b00};
    localparam logic [8:0] cnt_adr = {RFH_IDX_COUNT, 2'b00};
    localparam logic [8:0] ctl_adr = {RFH_IDX_CTRL, 2'b00};
    localparam logic [8:0] info_adr = {RFH_IDX_INFO, 2'b00};
    localparam logic [47:0] uni = 48'h0200_0000_0001;
    localparam logic [47:0] bc = 48'hFFFF_FFFF_FFFF;
    logic clk, reset_n, wb_cyc, wb_stb, wb_we, wb_ack_o, frame_kept, frame_dropped;
    logic rx_done;
    logic [8:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat, wb_dat_o, rd;
    logic [11:0] rx_len;
    logic [47:0] rx_dest_addr;
    logic [15:0] rx_len_type;
    logic [6:0] rx_err;
    logic pass_bad;
    int err_count, check_count;

    rfh_mac_model rfh_mac_model_inst (.clk(clk), .rx_done(rx_done), .rx_len(rx_len),
        .rx_dest_addr(rx_dest_addr), .rx_len_type(rx_len_type), .rx_err(rx_err));

    rfh_rx_status #(.DEPTH(2)) rfh_rx_status_inst (.clk(clk), .reset_n(reset_n),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .rx_done(rx_done), .rx_len(rx_len), .rx_dest_addr(rx_dest_addr),
        .rx_len_type(rx_len_type), .rx_icmp_cksum_err(rx_err[6]),
        .rx_ip_cksum_err(rx_err[5]), .rx_tcp_cksum_err(rx_err[4]),
        .rx_udp_cksum_err(rx_err[3]), .rx_symbol_err(rx_err[2]), .rx_runt(rx_err[1]),
        .rx_crc_err(rx_err[0]), .frame_kept(frame_kept), .frame_dropped(frame_dropped));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic test_done();
        if (err_count == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // classic single cycle; waits for ack however long, only the watchdog ends a hang
    task automatic wb_xfer(input logic we, input logic [8:0] adr, input logic [31:0] wd,
        output logic [31:0] rdat);
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat <= wd;
        @(posedge clk);
        while (wb_ack_o !== 1'b1)
        begin
            @(posedge clk);
        end
        rdat = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask

    function automatic logic [31:0] expst(input logic [11:0] len, input logic [47:0] da,
        input logic [15:0] lt, input logic [6:0] e);
        return {16'h0, 1'b1, 1'b0, e[6:3], 2'b00, da === bc, da[40], !da[40], e[2],
            lt > 16'h05DC, len > 12'h7D0, e[1:0]};
    endfunction

    // one frame in, then its status and count read back at once
    task automatic frame(input logic [11:0] len, input logic [47:0] da,
        input logic [15:0] lt, input logic [6:0] e);
        logic keep;
        logic [31:0] msk;
        keep = !(len > 12'h7D0 || e[1] || e[0]) || pass_bad;
        msk = e[1] ? 32'hFFFF_FFF7 : 32'hFFFF_FFFF; // type bit is noise on runts
        rfh_mac_model_inst.send(len, da, lt, e);
        #1;
        chk({31'h0, frame_kept}, {31'h0, keep});
        chk({31'h0, frame_dropped}, {31'h0, !keep});
        wb_xfer(1'b0, st_adr, 32'h0, rd);
        chk(rd & msk, keep ? expst(len, da, lt, e) & msk : 32'h0);
        wb_xfer(1'b0, cnt_adr, 32'h0, rd);
        chk(rd, keep ? {20'h0, len} : 32'h0);
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        test_done();
    end

    initial
    begin
        reset_n = 1'b0;
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat, pass_bad} = '0;
        wb_sel = 4'hF;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        wb_xfer(1'b1, st_adr, 32'hFFFF, rd);
        wb_xfer(1'b0, st_adr, 32'h0, rd);
        chk(rd, 32'h0);
        wb_xfer(1'b0, cnt_adr, 32'h0, rd);
        chk(rd, 32'h0);
        wb_xfer(1'b0, 9'h000, 32'h0, rd);
        chk(rd, 32'h0);
        frame(12'h040, uni, 16'h0800, 7'h7C);
        frame(12'h05C, bc, 16'h05DC, 7'h00);
        frame(12'h100, 48'h0100_5E00_0001, 16'h05DD, 7'h40);
        frame(12'h7D1, uni, 16'h0800, 7'h00);
        frame(12'h03C, uni, 16'h0800, 7'h02);
        frame(12'h040, uni, 16'h0800, 7'h01);
        wb_xfer(1'b1, ctl_adr, 32'h1, rd);
        pass_bad = 1'b1;
        frame(12'h7D1, uni, 16'h0800, 7'h00);
        frame(12'hFFF, bc, 16'h0800, 7'h00);
        frame(12'h7D0, uni, 16'h0800, 7'h20);
        frame(12'h03C, uni, 16'h0800, 7'h02);
        frame(12'h040, uni, 16'h0100, 7'h01);
        // two pending frames come out in arrival order, one per count read
        rfh_mac_model_inst.send(12'h0A5, uni, 16'h0800, 7'h08);
        rfh_mac_model_inst.send(12'h0A6, bc, 16'h0600, 7'h10);
        wb_xfer(1'b0, st_adr, 32'h0, rd);
        chk(rd, expst(12'h0A5, uni, 16'h0800, 7'h08));
        wb_xfer(1'b0, cnt_adr, 32'h0, rd);
        chk(rd, 32'h0A5);
        wb_xfer(1'b0, st_adr, 32'h0, rd);
        chk(rd, expst(12'h0A6, bc, 16'h0600, 7'h10));
        wb_xfer(1'b0, cnt_adr, 32'h0, rd);
        chk(rd, 32'h0A6);
        wb_xfer(1'b0, cnt_adr, 32'h0, rd);
        chk(rd, 32'h0);
        // a third frame finds the two-deep queue full; the loss stays flagged
        rfh_mac_model_inst.send(12'h0B1, uni, 16'h0800, 7'h00);
        rfh_mac_model_inst.send(12'h0B2, bc, 16'h0800, 7'h00);
        rfh_mac_model_inst.send(12'h0B3, uni, 16'h0800, 7'h00);
        #1;
        chk({31'h0, frame_dropped}, 32'h1);
        wb_xfer(1'b0, info_adr, 32'h0, rd);
        chk(rd, 32'h0000_0102);
        wb_xfer(1'b1, info_adr, 32'h100, rd);
        wb_xfer(1'b0, info_adr, 32'h0, rd);
        chk(rd, 32'h0000_0002);
        wb_xfer(1'b0, ctl_adr, 32'h0, rd);
        chk(rd, 32'h1);
        wb_xfer(1'b0, st_adr, 32'h0, rd);
        chk(rd, expst(12'h0B1, uni, 16'h0800, 7'h00));
        wb_xfer(1'b0, cnt_adr, 32'h0, rd);
        chk(rd, 32'h0B1);
        wb_xfer(1'b0, st_adr, 32'h0, rd);
        chk(rd, expst(12'h0B2, bc, 16'h0800, 7'h00));
        wb_xfer(1'b0, cnt_adr, 32'h0, rd);
        chk(rd, 32'h0B2);
        test_done();
    end
endmodule
